// File: logic/lamp_map.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * diagnostic lamp encoder; assumes a 250 MHz module clock
 */
`ifndef LAMP_MAP_SVH
`define LAMP_MAP_SVH

// clock and lamp timing, each figure in its own unit
`define CLK_HZ 250000000
`define SLOW_FLASH_HZ 1
`define FAST_FLASH_HZ 3
`define PULSE_MS 200
`define SEC_MS 1000
`define HOLD_S 60

// derived cycle counts; half periods round down, slot and second are exact
`define SLOW_HALF_CYC (`CLK_HZ / (2 * `SLOW_FLASH_HZ))
`define FAST_HALF_CYC (`CLK_HZ / (2 * `FAST_FLASH_HZ))
`define PULSE_CYC ((`CLK_HZ / 1000) * `PULSE_MS)
`define SEC_CYC ((`CLK_HZ / 1000) * `SEC_MS)

// pulse group: seven on/off pairs, then a four slot pause
`define SLOT_LAST 5'h11

// register map (byte addresses)
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define CODE_OFS 12'h008
`define CTRL_RST 2'h0
`define CTRL_IDENT_BIT 0
`define CTRL_DARK_BIT 1

`endif

// File: logic/lamp_pkg.sv
/*
 * types shared by the diagnostic lamp encoder and its bench;
 * assumes nothing beyond a SystemVerilog compiler
 */
package lamp_pkg;

   // per device port status from the safety logic
   typedef struct packed {
      logic [6:0] fault;   // bit n-1 set: fault with n pulse code
      logic ack_pend;      // fault may now be acknowledged
      logic in_a;          // safety input 1 level
      logic in_b;          // safety input 2 level
      logic in_err;        // discrepancy or stable time error
   } port_in_t;

   // module level status
   typedef struct packed {
      logic run;           // module in run state
      logic ack_pend;      // module fault may be acknowledged
      logic internal;      // internal module fault
      logic wd_expired;    // safety watchdog time exceeded
      logic [5:0] fault;   // bit n-1 set: module fault with n pulse code
   } mod_in_t;

   // network side status
   typedef struct packed {
      logic [1:0] link;    // link up per network port
      logic [1:0] active;  // frames moving per network port
      logic slow;          // link only at a slow rate
      logic cyclic;        // cyclic process data exchanged
   } net_in_t;

   // supply comparators
   typedef struct packed {
      logic below_20;
      logic below_17;
      logic below_12;
   } supply_in_t;

   // one bicolour lamp
   typedef struct packed {
      logic red;
      logic green;
   } lamp2_t;

endpackage

// File: logic/lamp_diag.sv
/*
 * diagnostic lamp encoder: steady, flashing and pulse count patterns
 * for port, network and central lamps, with an APB register slave;
 * assumes status inputs synchronous to CLK and an APB master that waits for PREADY
 */
// Implementation choices: the placing of the registers and the APB interface to the registers.
// What this block does
// - port fault lamp steady green when the port has no fault.
// - port fault lamp flashes green while a port fault awaits acknowledgement.
// - port fault lamp flashes red groups of one to six naming the fault.
// - seven pulse feedback interface code only on device ports four to seven.
// - port red code held about sixty seconds after the fault vanishes.
// - input lamp off both low, on both high, flashing otherwise or error.
// - link lamp steady green while the network port has link.
// - activity lamp flashes while frames move on that network port.
// - system failure lamp steady red on any module or port error.
// - system failure lamp flashes green when identification is requested.
// - bus failure lamp steady red with no link or a slow link.
// - bus failure lamp flashes red with link but no cyclic data.
// - module lamp flashes green in run while a module fault awaits acknowledgement.
// - module lamp steady red on internal module fault.
// - module lamp flashes red at three hertz on watchdog expiry.
// - module lamp flashes red groups of one to six naming the fault.
// - supply lamp green when fine, one hertz flash below 20 V.
// - supply lamp flashes at three hertz below 17 V.
// - supply lamp off below 12 V.
`timescale 1ns/1ps
`default_nettype none
`include "lamp_map.svh"

module lamp_diag #(
   parameter logic [31:0] SLOW_HALF_CYC = `SLOW_HALF_CYC,
   parameter logic [31:0] FAST_HALF_CYC = `FAST_HALF_CYC,
   parameter logic [31:0] PULSE_CYC = `PULSE_CYC,
   parameter logic [31:0] SEC_CYC = `SEC_CYC
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire lamp_pkg::port_in_t [7:0] PORT_IN,
   input wire lamp_pkg::mod_in_t MOD_IN,
   input wire lamp_pkg::net_in_t NET_IN,
   input wire lamp_pkg::supply_in_t SUPPLY_IN,
   output lamp_pkg::lamp2_t [7:0] PORT_FAULT_LAMP,
   output logic [7:0] PORT_INPUT_LAMP,
   output logic [1:0] LINK_LAMP,
   output logic [1:0] ACTIVITY_LAMP,
   output lamp_pkg::lamp2_t SYSTEM_FAILURE_LAMP,
   output logic BUS_FAILURE_LAMP,
   output lamp_pkg::lamp2_t MODULE_LAMP,
   output logic SUPPLY_LAMP
);

   // lowest set bit gives the pulse count, zero when none is set
   function automatic logic [2:0] pick_code(input logic [6:0] f);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (f[i]) begin
            c = 3'(i + 1);
         end
      end
      return c;
   endfunction

   // lit during even slots below twice the count
   function automatic logic pulse_lit(input logic [2:0] code, input logic [4:0] slot);
      return (code != 3'h0) && !slot[0] && (slot < {1'b0, code, 1'b0});
   endfunction

   // free running flash sources, shared so all lamps blink in step
   logic [31:0] slow_cnt_r, fast_cnt_r, slot_cnt_r, sec_cnt_r;
   logic slow_ph_r, fast_ph_r;
   logic [4:0] slot_r;
   wire slow_end = (slow_cnt_r == SLOW_HALF_CYC - 32'h1);
   wire fast_end = (fast_cnt_r == FAST_HALF_CYC - 32'h1);
   wire slot_end = (slot_cnt_r == PULSE_CYC - 32'h1);
   wire sec_tick = (sec_cnt_r == SEC_CYC - 32'h1);

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         slow_cnt_r <= 32'h0;
         fast_cnt_r <= 32'h0;
         slot_cnt_r <= 32'h0;
         sec_cnt_r <= 32'h0;
         slow_ph_r <= 1'b0;
         fast_ph_r <= 1'b0;
         slot_r <= 5'h0;
      end else begin
         slow_cnt_r <= slow_end ? 32'h0 : slow_cnt_r + 32'h1;
         fast_cnt_r <= fast_end ? 32'h0 : fast_cnt_r + 32'h1;
         slot_cnt_r <= slot_end ? 32'h0 : slot_cnt_r + 32'h1;
         sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
         slow_ph_r <= slow_ph_r ^ slow_end;
         fast_ph_r <= fast_ph_r ^ fast_end;
         // group wraps after a four slot pause, longer than the one slot gap
         if (slot_end) begin
            slot_r <= (slot_r == `SLOT_LAST) ? 5'h0 : slot_r + 5'h1;
         end
      end
   end

   // software control: identification blink and a dark switch
   logic [1:0] ctrl_r;
   wire ident = ctrl_r[`CTRL_IDENT_BIT];
   wire dark = ctrl_r[`CTRL_DARK_BIT];

   // per port code selection and hold timer
   logic [2:0] held_code_r [8];
   logic [5:0] hold_s_r [8];
   logic [2:0] live_code [8];
   logic [2:0] shown_code [8];
   lamp_pkg::lamp2_t port_lamp_nxt [8];
   logic [7:0] in_lamp_nxt;
   logic [7:0] port_err;

   for (genvar p = 0; p < 8; p++) begin : g_port
      // feedback interface code exists only on the upper four ports
      wire [6:0] fmask = (p >= 4) ? 7'h7f : 7'h3f;
      assign live_code[p] = pick_code(PORT_IN[p].fault & fmask);
      // faults lost on passivation keep their code for the hold time
      assign shown_code[p] = (live_code[p] != 3'h0) ? live_code[p] :
         ((hold_s_r[p] != 6'h0) ? held_code_r[p] : 3'h0);
      assign port_err[p] = (shown_code[p] != 3'h0);
      assign port_lamp_nxt[p].red = pulse_lit(shown_code[p], slot_r) && !dark;
      assign port_lamp_nxt[p].green = !port_err[p] && !dark &&
         (!PORT_IN[p].ack_pend || slow_ph_r);
      assign in_lamp_nxt[p] = !dark && ((PORT_IN[p].in_a && PORT_IN[p].in_b &&
         !PORT_IN[p].in_err) || ((PORT_IN[p].in_a ^ PORT_IN[p].in_b || PORT_IN[p].in_err)
         && slow_ph_r));

      // reload on a live fault, count seconds down once it is gone
      always_ff @(posedge CLK or posedge RESET) begin
         if (RESET) begin
            held_code_r[p] <= 3'h0;
            hold_s_r[p] <= 6'h0;
         end else if (live_code[p] != 3'h0) begin
            held_code_r[p] <= live_code[p];
            hold_s_r[p] <= 6'(`HOLD_S);
         end else if (sec_tick && hold_s_r[p] != 6'h0) begin
            hold_s_r[p] <= hold_s_r[p] - 6'h1;
         end
      end
   end

   // network lamps
   wire [1:0] link_nxt = dark ? 2'h0 : NET_IN.link;
   wire [1:0] act_nxt = dark ? 2'h0 : (NET_IN.active & {2{fast_ph_r}});
   wire link_any = |NET_IN.link;
   wire bus_nxt = !dark && ((!link_any || NET_IN.slow) ||
      (!NET_IN.cyclic && slow_ph_r));

   // module lamp: internal beats watchdog beats codes beats green states
   wire [2:0] mod_code = pick_code({1'b0, MOD_IN.fault});
   wire mod_err = MOD_IN.internal || MOD_IN.wd_expired || (mod_code != 3'h0);
   lamp_pkg::lamp2_t mod_nxt, sf_nxt;
   assign mod_nxt.red = !dark && (MOD_IN.internal ||
      (MOD_IN.wd_expired && fast_ph_r) ||
      (!MOD_IN.wd_expired && pulse_lit(mod_code, slot_r)));
   assign mod_nxt.green = !dark && !mod_err && MOD_IN.run &&
      (!MOD_IN.ack_pend || slow_ph_r);

   // system failure lamp: red error wins over identification blink
   wire any_err = mod_err || (|port_err);
   assign sf_nxt.red = !dark && any_err;
   assign sf_nxt.green = !dark && !any_err && ident && slow_ph_r;

   // supply lamp from the three comparator levels
   wire sup_nxt = !dark && !SUPPLY_IN.below_12 && (
      SUPPLY_IN.below_17 ? fast_ph_r :
      (SUPPLY_IN.below_20 ? slow_ph_r : 1'b1));

   // all lamp outputs come from flip-flops
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         PORT_FAULT_LAMP <= '0;
         PORT_INPUT_LAMP <= 8'h0;
         LINK_LAMP <= 2'h0;
         ACTIVITY_LAMP <= 2'h0;
         SYSTEM_FAILURE_LAMP <= '0;
         BUS_FAILURE_LAMP <= 1'b0;
         MODULE_LAMP <= '0;
         SUPPLY_LAMP <= 1'b0;
      end else begin
         for (int p = 0; p < 8; p++) begin
            PORT_FAULT_LAMP[p] <= port_lamp_nxt[p];
         end
         PORT_INPUT_LAMP <= in_lamp_nxt;
         LINK_LAMP <= link_nxt;
         ACTIVITY_LAMP <= act_nxt;
         SYSTEM_FAILURE_LAMP <= sf_nxt;
         BUS_FAILURE_LAMP <= bus_nxt;
         MODULE_LAMP <= mod_nxt;
         SUPPLY_LAMP <= sup_nxt;
      end
   end

   // apb slave: one wait state so read data comes from a flip-flop
   wire acc = PSEL && PENABLE && !PREADY;
   wire hit_ctrl = (PADDR == `CTRL_OFS);
   wire hit_stat = (PADDR == `STATUS_OFS);
   wire hit_code = (PADDR == `CODE_OFS);
   wire mapped = hit_ctrl || hit_stat || (hit_code && !PWRITE);
   wire [31:0] stat_word = {14'h0, SUPPLY_LAMP, MODULE_LAMP, BUS_FAILURE_LAMP,
      SYSTEM_FAILURE_LAMP, ACTIVITY_LAMP, LINK_LAMP, PORT_INPUT_LAMP};
   wire [31:0] code_word = {8'h0, shown_code[7], shown_code[6], shown_code[5],
      shown_code[4], shown_code[3], shown_code[2], shown_code[1], shown_code[0]};
   wire [31:0] rd_nxt = hit_ctrl ? {30'h0, ctrl_r} :
      (hit_stat ? stat_word : (hit_code ? code_word : 32'h0));

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_r <= `CTRL_RST;
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= acc;
         PSLVERR <= acc && !mapped;
         PRDATA <= (acc && !PWRITE) ? rd_nxt : 32'h0;
         if (acc && PWRITE && hit_ctrl) begin
            ctrl_r <= PWDATA[1:0];
         end
      end
   end

endmodule

`default_nettype wire

// File: testbench/lamp_diag_asserts.sv
/* port relations of the lamp encoder; assumes one clock and no dark bit set */
`timescale 1ns/1ps
`default_nettype none
module lamp_diag_asserts (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire lamp_pkg::port_in_t [7:0] PORT_IN,
   input wire lamp_pkg::mod_in_t MOD_IN,
   input wire lamp_pkg::net_in_t NET_IN,
   input wire lamp_pkg::supply_in_t SUPPLY_IN,
   input wire lamp_pkg::lamp2_t [7:0] PORT_FAULT_LAMP,
   input wire logic [7:0] PORT_INPUT_LAMP,
   input wire logic [1:0] LINK_LAMP,
   input wire lamp_pkg::lamp2_t SYSTEM_FAILURE_LAMP,
   input wire logic BUS_FAILURE_LAMP,
   input wire lamp_pkg::lamp2_t MODULE_LAMP,
   input wire logic SUPPLY_LAMP
);
   // every lamp lags its cause by one clock, so causes are checked a cycle on
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   AST_LINK: assert property (1'b1 |=> LINK_LAMP == $past(NET_IN.link))
      else $error("link lamp does not follow link");
   AST_IN_ON: assert property (PORT_IN[3].in_a && PORT_IN[3].in_b && !PORT_IN[3].in_err
      |=> PORT_INPUT_LAMP[3]) else $error("input lamp not lit");
   AST_IN_OFF: assert property (!PORT_IN[2].in_a && !PORT_IN[2].in_b && !PORT_IN[2].in_err
      |=> !PORT_INPUT_LAMP[2]) else $error("input lamp lit");
   AST_SUP_OFF: assert property (SUPPLY_IN.below_12 |=> !SUPPLY_LAMP)
      else $error("supply lamp lit below 12 V");
   AST_SUP_ON: assert property (!SUPPLY_IN.below_20 |=> SUPPLY_LAMP)
      else $error("supply lamp dark with good supply");
   AST_MOD_RED: assert property (MOD_IN.internal |=> MODULE_LAMP == 2'h2)
      else $error("module lamp not steady red");
   AST_SF_RED: assert property (MOD_IN.internal |=> SYSTEM_FAILURE_LAMP.red)
      else $error("system failure lamp not red");
   AST_BF: assert property (NET_IN.slow || NET_IN.link == 2'h0 |=> BUS_FAILURE_LAMP)
      else $error("bus failure lamp not steady");
   AST_RED_WINS: assert property (PORT_FAULT_LAMP[5].red |-> !PORT_FAULT_LAMP[5].green)
      else $error("port lamp red and green at once");
   AST_ACK: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("ready not a one cycle answer");
endmodule
bind lamp_diag lamp_diag_asserts lamp_diag_asserts_inst (.CLK(CLK), .RESET(RESET),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PORT_IN(PORT_IN), .MOD_IN(MOD_IN),
   .NET_IN(NET_IN), .SUPPLY_IN(SUPPLY_IN), .PORT_FAULT_LAMP(PORT_FAULT_LAMP),
   .PORT_INPUT_LAMP(PORT_INPUT_LAMP), .LINK_LAMP(LINK_LAMP),
   .SYSTEM_FAILURE_LAMP(SYSTEM_FAILURE_LAMP), .BUS_FAILURE_LAMP(BUS_FAILURE_LAMP),
   .MODULE_LAMP(MODULE_LAMP), .SUPPLY_LAMP(SUPPLY_LAMP));
`default_nettype wire

// File: testbench/lamp_viewer.sv
/* an observer that reads pulse groups off one lamp; assumes slots of SLOT cycles */
`timescale 1ns/1ps
`default_nettype none
module lamp_viewer #(parameter int SLOT = 4) (
   input wire logic clk,
   input wire logic lamp,
   output int count
);
   int dark = 0;
   int run = 0;
   logic prev = 1'b0;
   // a dark spell longer than two slots closes a group, the gap never is
   always @(posedge clk) begin
      prev <= lamp;
      dark <= lamp ? 0 : dark + 1;
      if (lamp && !prev) run <= run + 1;
      if (dark == 2 * SLOT + 1) begin
         count <= run;
         run <= 0;
      end
   end
endmodule
`default_nettype wire

// File: testbench/lamp_diag_tb_top.sv
/* bench of the lamp encoder over APB; assumes small timing parameters 8,4,4,16 */
`timescale 1ns/1ps
`default_nettype none
module lamp_diag_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, exp_code;
   logic pready, pslverr, e, bf_lamp, sup_lamp;
   lamp_pkg::port_in_t [7:0] port_in = '0;
   lamp_pkg::mod_in_t mod_in = '0;
   lamp_pkg::net_in_t net_in = '0;
   lamp_pkg::supply_in_t supply_in = '0;
   lamp_pkg::lamp2_t [7:0] port_lamp;
   lamp_pkg::lamp2_t sf_lamp, mod_lamp;
   logic [7:0] in_lamp, probe;
   logic [1:0] link_lamp, act_lamp;
   int cnt [9];
   int miscompares = 0, total_checks = 0, cycles = 0;
   always #2 clk = ~clk;
   lamp_diag #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(4), .PULSE_CYC(4), .SEC_CYC(16))
   lamp_diag_inst (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PORT_IN(port_in), .MOD_IN(mod_in), .NET_IN(net_in),
      .SUPPLY_IN(supply_in), .PORT_FAULT_LAMP(port_lamp), .PORT_INPUT_LAMP(in_lamp),
      .LINK_LAMP(link_lamp), .ACTIVITY_LAMP(act_lamp), .SYSTEM_FAILURE_LAMP(sf_lamp),
      .BUS_FAILURE_LAMP(bf_lamp), .MODULE_LAMP(mod_lamp), .SUPPLY_LAMP(sup_lamp));
   // one observer per pulse coded red lamp: ports 0 to 7, then the module lamp
   for (genvar i = 0; i < 9; i++) begin : eye
      lamp_viewer #(.SLOT(4)) lamp_viewer_inst (.clk(clk),
         .lamp(i < 8 ? port_lamp[i % 8].red : mod_lamp.red), .count(cnt[i]));
   end
   assign probe = {sf_lamp.green, sup_lamp, mod_lamp.red, mod_lamp.green, bf_lamp,
      act_lamp[0], in_lamp[1], port_lamp[0].green};
   task test_done();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // request held until ready is seen high at a rising edge, released after it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // time between two changes of a flashing lamp is one half period
   task flash(input int i, input int half);
      int n;
      logic v;
      // the first change may come from the new stimulus, so measure after the second
      @(negedge clk);
      repeat (2) begin
         v = probe[i];
         n = 0;
         while (probe[i] === v && n < 40) begin @(negedge clk); n++; end
      end
      v = probe[i];
      n = 0;
      while (probe[i] === v && n < 40) begin @(negedge clk); n++; end
      chk("flash half period", half, n);
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      apb(0, 12'h000, 0);
      chk("ctrl reset", 0, q);
      apb(0, 12'h00c, 0);
      chk("unmapped refused", 1, e);
      apb(1, 12'h008, 1);
      chk("code write refused", 1, e);
      apb(1, 12'h000, 1);
      apb(0, 12'h000, 0);
      chk("ctrl ident", 1, q);
      // packed: port {fault,ack,a,b,err}, net {link,act,slow,cyc}, module {run,ack,int,wd,code}
      port_in[0] <= 11'h008;
      port_in[1] <= 11'h004;
      port_in[3] <= 11'h006;
      net_in <= 6'h34;
      mod_in <= 10'h200;
      supply_in <= 3'h4;
      flash(0, 8);
      flash(1, 8);
      flash(2, 4);
      flash(3, 8);
      flash(6, 8);
      flash(7, 8);
      chk("module green", 2'h1, mod_lamp);
      chk("ports green", 12'h555, port_lamp[7:2]);
      chk("input lamps", 2'h2, in_lamp[3:2]);
      mod_in <= 10'h300;
      flash(4, 8);
      mod_in <= 10'h240;
      supply_in <= 3'h6;
      flash(5, 4);
      flash(6, 4);
      // port p carries code p, port 1 two codes, port 0 a code it may not show
      mod_in <= 10'h224;
      port_in[0] <= 11'h400;
      for (int p = 1; p < 8; p++) port_in[p].fault <= (p == 1) ? 7'h21 : 7'(1 << (p - 1));
      repeat (200) @(posedge clk);
      exp_code = 0;
      for (int p = 0; p < 8; p++) exp_code |= 32'(p) << (3 * p);
      for (int p = 0; p < 8; p++) chk("port group", p, cnt[p]);
      chk("module group", 3, cnt[8]);
      chk("system red", 1, sf_lamp.red);
      apb(0, 12'h008, 0);
      chk("code register", exp_code, q);
      // a wrong acknowledgement length comes in as the four pulse module code
      mod_in <= 10'h208;
      repeat (200) @(posedge clk);
      chk("ack length code", 4, cnt[8]);
      port_in <= '0;
      mod_in <= 10'h200;
      repeat (900) @(posedge clk);
      apb(0, 12'h008, 0);
      chk("code held", exp_code, q);
      repeat (100) @(posedge clk);
      apb(0, 12'h008, 0);
      chk("code released", 0, q);
      chk("all ports green", 16'h5555, port_lamp);
      mod_in <= 10'h080;
      net_in <= 6'h02;
      supply_in <= 3'h7;
      repeat (20) @(posedge clk);
      chk("module red", 2'h2, mod_lamp);
      apb(0, 12'h004, 0);
      chk("status word", 32'h00016000, q);
      test_done();
   end
endmodule
`default_nettype wire
